// ### include/led_drive_defines.svh
// Offsets, field positions, reset values and fixed-point constants.
// Assumes inclusion by bare name; definitions only.
`ifndef LED_DRIVE_DEFINES_SVH
`define LED_DRIVE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define FIRST_DRIVE_IDX 8'h23
`define SECOND_DRIVE_IDX 8'h24
`define FINE_ADJUST_IDX 8'h25
`define ADDR_W 12
`define FIRST_DRIVE_ADDR 12'h08c
`define SECOND_DRIVE_ADDR 12'h090
`define FINE_ADJUST_ADDR 12'h094

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCALE_BIT 13
`define FIXED_ONE_BIT 12
`define EDGE_HI 6
`define EDGE_LO 4
`define COARSE_HI 3
`define COARSE_LO 0
`define FIRST_FINE_HI 4
`define FIRST_FINE_LO 0
`define SECOND_FINE_HI 10
`define SECOND_FINE_LO 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DRIVE_RESET 16'h3000
`define FINE_CODE_RESET 5'h0c
`define FINE_ADJUST_RESET 16'h030c

// ----------------------------------------------------------------------
// Fixed-point figures, scaled by 1000 (milliamps or unitless)
// ----------------------------------------------------------------------
`define COARSE_BASE_MILLI 32'd28000
`define COARSE_STEP_MILLI 32'd15460
`define FINE_BASE_MILLI 32'd710
`define FINE_STEP_MILLI 32'd24
`define SCALE_BASE_MILLI 32'd400
`define SCALE_STEP_MILLI 32'd600

`endif

// ### include/led_drive_pkg.sv
// Types shared by the LED drive configuration block.
// Assumes the defines header is compiled with it.
package led_drive_pkg;

  typedef struct packed {
    logic strength_full;
    logic [2:0] edge_rate_code;
    logic [3:0] coarse_code;
    logic [4:0] fine_code;
  } drive_setting_type;

  typedef struct packed {
    logic [31:0] coarse_micro;
    logic [31:0] fine_milli;
    logic [31:0] scale_milli;
  } drive_target_type;

endpackage : led_drive_pkg

// ### rtl/led_target_calc.sv
// Peak current target of one LED sink from its coarse, fine and scale codes.
// Assumes codes from flip-flops on the same clock; result is registered.
`timescale 1ns/1ps
`include "led_drive_defines.svh"

module led_target_calc (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire led_drive_pkg::drive_setting_type setting,
  output led_drive_pkg::drive_target_type target
);

  typedef struct packed {
    led_drive_pkg::drive_target_type target;
  } state_type;

  state_type state_q;
  state_type state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.target.coarse_micro = `COARSE_BASE_MILLI +
      `COARSE_STEP_MILLI * {28'h0000000, setting.coarse_code}; // [RL6] [RL7]
    state_d.target.fine_milli = `FINE_BASE_MILLI +
      `FINE_STEP_MILLI * {27'h0000000, setting.fine_code}; // [RL8] [RL9]
    state_d.target.scale_milli = `SCALE_BASE_MILLI +
      (setting.strength_full ? `SCALE_STEP_MILLI : 32'h0); // [RL3]
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= '0;
    else if (clk_en)
      state_q <= state_d;
  end

  assign target = state_q.target;

endmodule : led_target_calc

// ### rtl/axil_slave_port.sv
// AXI4-Lite slave handshake: captures one write and one read, answers OKAY
// or SLVERR. Assumes the register file decodes addresses combinationally.
`timescale 1ns/1ps

module axil_slave_port #(
  parameter int AW = 12
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_go,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [AW-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;

  state_type state_q;
  state_type state_d;
  logic go;

  // The register map needs at least eight address bits to be decoded.
  if (AW < 8)
  begin : g_aw_check
    $error("address width too narrow for the register map");
  end

  // A write commits the cycle both halves are held and no answer is pending.
  assign go = state_q.aw_have && state_q.w_have && !state_q.bvalid;

  always_comb
  begin
    state_d = state_q;
    if (awvalid && !state_q.aw_have)
    begin
      state_d.aw_have = 1'b1;
      state_d.waddr = awaddr;
    end
    if (wvalid && !state_q.w_have)
    begin
      state_d.w_have = 1'b1;
      state_d.wdat = wdata;
      state_d.wstr = wstrb;
    end
    if (go)
    begin
      state_d.aw_have = 1'b0;
      state_d.w_have = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = wr_ok ? 2'h0 : 2'h2;
    end
    if (state_q.bvalid && bready)
      state_d.bvalid = 1'b0;
    if (arvalid && !state_q.rvalid)
    begin
      state_d.rvalid = 1'b1;
      state_d.rdata = rd_ok ? rd_data : 32'h0;
      state_d.rresp = rd_ok ? 2'h0 : 2'h2;
    end
    if (state_q.rvalid && rready)
      state_d.rvalid = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= '0;
    else if (clk_en)
      state_q <= state_d;
  end

  assign awready = !state_q.aw_have;
  assign wready = !state_q.w_have;
  assign bvalid = state_q.bvalid;
  assign bresp = state_q.bresp;
  assign arready = !state_q.rvalid;
  assign rvalid = state_q.rvalid;
  assign rdata = state_q.rdata;
  assign rresp = state_q.rresp;
  assign wr_go = go && clk_en;
  assign wr_addr = state_q.waddr;
  assign wr_data = state_q.wdat;
  assign wr_strb = state_q.wstr;
  assign rd_addr = araddr;

endmodule : axil_slave_port

// ### rtl/led_drive_config_regs.sv
// Drive configuration registers of the first and second LED current sinks.
// Assumes an AXI4-Lite master on sys_clk; outputs feed analog LED drivers.
//
// Notes on behaviour
// RL1: Bit 13 of the first drive register selects full strength when set.
// RL2: Bit 13 of the second drive register, index second_led_drive_setting, means the same.
// RL3: The scale multiplier is 0.4 plus 0.6 times the strength bit.
// RL4: Bits 6 to 4 of the first register hold its edge rate, 0 slowest.
// RL5: Bits 6 to 4 of the second register hold its own edge rate code.
// RL6: Bits 3 to 0 of the first register give a coarse 28 + 15.46*code mA.
// RL7: The second coarse code in bits 3 to 0 decodes the same way.
// RL8: First peak is coarse*fine*scale, fine code in fine bits 4 to 0.
// RL9: Second peak uses the fine code in fine-adjust bits 10 to 6.
// RL10: Software writes reserved bits as zero, bit 12 as one.
// RL11: Each fine-adjust code resets to 0xc.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "led_drive_defines.svh"

module led_drive_config_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic first_low_power,
  output logic second_low_power,
  output led_drive_pkg::drive_setting_type first_emitter_output,
  output led_drive_pkg::drive_setting_type second_emitter_output,
  output led_drive_pkg::drive_target_type first_peak_target,
  output led_drive_pkg::drive_target_type second_peak_target
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] first_drive;
    logic [15:0] second_drive;
    logic [15:0] fine_adjust;
    led_drive_pkg::drive_setting_type first_set;
    led_drive_pkg::drive_setting_type second_set;
    logic first_lp;
    logic second_lp;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic wr_go;
  logic [`ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [`ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  axil_slave_port #(
    .AW(`ADDR_W)
  ) bus (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_go(wr_go),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // --------------------------------------------------------------------
  // Byte-lane merge
  // --------------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0])
      r[7:0] = data[7:0];
    if (strb[1])
      r[15:8] = data[15:8];
    return r;
  endfunction : merge

  // --------------------------------------------------------------------
  // Decode and next state
  // --------------------------------------------------------------------
  always_comb
  begin
    wr_ok = (wr_addr == `FIRST_DRIVE_ADDR) ||
            (wr_addr == `SECOND_DRIVE_ADDR) ||
            (wr_addr == `FINE_ADJUST_ADDR);
    rd_ok = 1'b1;
    case (rd_addr)
      `FIRST_DRIVE_ADDR: rd_data = {16'h0000, state_q.first_drive};
      `SECOND_DRIVE_ADDR: rd_data = {16'h0000, state_q.second_drive};
      `FINE_ADJUST_ADDR: rd_data = {16'h0000, state_q.fine_adjust};
      default:
      begin
        rd_data = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Reserved bits are stored as written; their correct values are left
  // to software, so a read shows bits 15 to 0 as last written and bits 31 to 16 as zero. [RL10]
  always_comb
  begin
    state_d = state_q;
    if (wr_go && wr_addr == `FIRST_DRIVE_ADDR)
      state_d.first_drive = merge(state_q.first_drive, wr_data, wr_strb);
    if (wr_go && wr_addr == `SECOND_DRIVE_ADDR)
      state_d.second_drive = merge(state_q.second_drive, wr_data, wr_strb);
    if (wr_go && wr_addr == `FINE_ADJUST_ADDR)
      state_d.fine_adjust = merge(state_q.fine_adjust, wr_data, wr_strb);
    state_d.first_set.strength_full = state_q.first_drive[`SCALE_BIT]; // [RL1]
    state_d.first_set.edge_rate_code =
      state_q.first_drive[`EDGE_HI:`EDGE_LO]; // [RL4]
    state_d.first_set.coarse_code =
      state_q.first_drive[`COARSE_HI:`COARSE_LO]; // [RL6]
    state_d.first_set.fine_code =
      state_q.fine_adjust[`FIRST_FINE_HI:`FIRST_FINE_LO]; // [RL8]
    state_d.second_set.strength_full =
      state_q.second_drive[`SCALE_BIT]; // [RL2]
    state_d.second_set.edge_rate_code =
      state_q.second_drive[`EDGE_HI:`EDGE_LO]; // [RL5]
    state_d.second_set.coarse_code =
      state_q.second_drive[`COARSE_HI:`COARSE_LO]; // [RL7]
    state_d.second_set.fine_code =
      state_q.fine_adjust[`SECOND_FINE_HI:`SECOND_FINE_LO]; // [RL9]
    state_d.first_lp = !state_q.first_drive[`SCALE_BIT]; // [RL1]
    state_d.second_lp = !state_q.second_drive[`SCALE_BIT]; // [RL2]
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q.first_drive <= `DRIVE_RESET;
      state_q.second_drive <= `DRIVE_RESET;
      state_q.fine_adjust <= `FINE_ADJUST_RESET; // [RL11]
      state_q.first_set <= {1'b1, 3'h0, 4'h0, `FINE_CODE_RESET};
      state_q.second_set <= {1'b1, 3'h0, 4'h0, `FINE_CODE_RESET};
      state_q.first_lp <= 1'b0;
      state_q.second_lp <= 1'b0;
    end
    else if (clk_en)
      state_q <= state_d;
  end

  // --------------------------------------------------------------------
  // Targets
  // --------------------------------------------------------------------
  led_target_calc first_calc (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .setting(state_q.first_set),
    .target(first_peak_target)
  );

  led_target_calc second_calc (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .setting(state_q.second_set),
    .target(second_peak_target)
  );

  assign first_emitter_output = state_q.first_set;
  assign second_emitter_output = state_q.second_set;
  assign first_low_power = state_q.first_lp;
  assign second_low_power = state_q.second_lp;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Target checks skip the release edge: the targets still hold their
  // cleared reset value for one edge after reset lets go.
  a_first_scale_lp: assert property (@(posedge sys_clk) // [RL1]
    disable iff (rst)
    clk_en |=> first_low_power == !$past(state_q.first_drive[13]))
    else $error("first low power does not follow strength bit");

  a_second_scale_lp: assert property (@(posedge sys_clk) // [RL2]
    disable iff (rst)
    clk_en |=> second_low_power == !$past(state_q.second_drive[13]))
    else $error("second low power does not follow strength bit");

  a_scale_value: assert property (@(posedge sys_clk) // [RL3]
    disable iff (rst)
    clk_en && !rst |=> first_peak_target.scale_milli ==
      ($past(state_q.first_set.strength_full) ? 32'd1000 : 32'd400))
    else $error("scale multiplier wrong");

  a_first_edge_rate: assert property (@(posedge sys_clk) // [RL4]
    disable iff (rst)
    clk_en |=> first_emitter_output.edge_rate_code ==
      $past(state_q.first_drive[6:4]))
    else $error("first edge rate field wrong");

  a_second_edge_rate: assert property (@(posedge sys_clk) // [RL5]
    disable iff (rst)
    clk_en |=> second_emitter_output.edge_rate_code ==
      $past(state_q.second_drive[6:4]))
    else $error("second edge rate field wrong");

  a_first_coarse_ma: assert property (@(posedge sys_clk) // [RL6]
    disable iff (rst)
    clk_en && !rst |=> first_peak_target.coarse_micro == 32'd28000 +
      32'd15460 * {28'h0, $past(state_q.first_set.coarse_code)})
    else $error("first coarse target wrong");

  a_second_coarse_ma: assert property (@(posedge sys_clk) // [RL7]
    disable iff (rst)
    clk_en && !rst |=> second_peak_target.coarse_micro == 32'd28000 +
      32'd15460 * {28'h0, $past(state_q.second_set.coarse_code)})
    else $error("second coarse target wrong");

  a_first_fine_mult: assert property (@(posedge sys_clk) // [RL8]
    disable iff (rst)
    (clk_en && !rst) ##1 clk_en |=> first_peak_target.fine_milli ==
      32'd710 + 32'd24 * {27'h0, $past(state_q.fine_adjust[4:0], 2)})
    else $error("first fine multiplier wrong");

  a_second_fine_mult: assert property (@(posedge sys_clk) // [RL9]
    disable iff (rst)
    (clk_en && !rst) ##1 clk_en |=> second_peak_target.fine_milli ==
      32'd710 + 32'd24 * {27'h0, $past(state_q.fine_adjust[10:6], 2)})
    else $error("second fine multiplier wrong");

  a_fine_reset: assert property (@(posedge sys_clk) // [RL11]
    $past(rst) |-> state_q.fine_adjust[4:0] == 5'h0c &&
      state_q.fine_adjust[10:6] == 5'h0c)
    else $error("fine codes not reset to 0xc");

  a_emitter_reset: assert property (@(posedge sys_clk) // [RL11]
    $past(rst) |-> first_emitter_output.fine_code == 5'h0c &&
      second_emitter_output.fine_code == 5'h0c)
    else $error("emitter fine codes not reset to 0xc");

  a_first_low_store: assert property (@(posedge sys_clk) // [RL4] [RL6]
    disable iff (rst)
    wr_go && wr_addr == `FIRST_DRIVE_ADDR && wr_strb[0] |=>
      state_q.first_drive[7:0] == $past(wr_data[7:0]))
    else $error("first drive low byte not stored");

  a_first_high_store: assert property (@(posedge sys_clk) // [RL1]
    disable iff (rst)
    wr_go && wr_addr == `FIRST_DRIVE_ADDR && wr_strb[1] |=>
      state_q.first_drive[15:8] == $past(wr_data[15:8]))
    else $error("first drive high byte not stored");

  a_second_store: assert property (@(posedge sys_clk) // [RL2] [RL5] [RL7]
    disable iff (rst)
    wr_go && wr_addr == `SECOND_DRIVE_ADDR && wr_strb[1:0] == 2'h3 |=>
      state_q.second_drive == $past(wr_data[15:0]))
    else $error("second drive word not stored");

  a_fine_store: assert property (@(posedge sys_clk) // [RL8] [RL9]
    disable iff (rst)
    wr_go && wr_addr == `FINE_ADJUST_ADDR && wr_strb[1:0] == 2'h3 |=>
      state_q.fine_adjust == $past(wr_data[15:0]))
    else $error("fine adjust word not stored");

  a_freeze_state: assert property (@(posedge sys_clk)
    disable iff (rst)
    !clk_en && !rst |=> $stable(state_q) && $stable(first_peak_target) &&
      $stable(second_peak_target) && $stable(s_axi_bvalid))
    else $error("state moved while the clock enable was low");

  a_write_release: assert property (@(posedge sys_clk)
    disable iff (rst)
    s_axi_bvalid && s_axi_bready && clk_en && !rst |=> !s_axi_bvalid)
    else $error("write answer not withdrawn after it was taken");

  a_read_release: assert property (@(posedge sys_clk)
    disable iff (rst)
    s_axi_rvalid && s_axi_rready && clk_en && !rst |=> !s_axi_rvalid)
    else $error("read answer not withdrawn after it was taken");

  a_read_answer: assert property (@(posedge sys_clk)
    disable iff (rst)
    s_axi_arvalid && s_axi_arready && clk_en && !rst |=> s_axi_rvalid)
    else $error("read answer missing one edge after the request");

  a_unmapped_error: assert property (@(posedge sys_clk)
    disable iff (rst)
    wr_go && !wr_ok |=> s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write not answered with an error");

endmodule : led_drive_config_regs

// ### test/led_drive_config_regs_tb.sv
// Self-checking bench for the LED drive configuration registers.
// Assumes the register file answers over AXI4-Lite on sys_clk.
`timescale 1ns/1ps
`include "led_drive_defines.svh"

module led_drive_config_regs_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic lp1, lp2;
  led_drive_pkg::drive_setting_type em1, em2;
  led_drive_pkg::drive_target_type tg1, tg2;
  int fail_count = 0;
  int samples_checked = 0;
  logic [1:0] resp;
  logic [31:0] rd;

  always #20 sys_clk = ~sys_clk;

  led_drive_config_regs uut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .first_low_power(lp1),
    .second_low_power(lp2), .first_emitter_output(em1),
    .second_emitter_output(em2), .first_peak_target(tg1),
    .second_peak_target(tg2)
  );

  // ----------------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------------
  task tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task overrun(input int n);
    if (n > 200)
    begin
      fail_count++;
      $display("wrong value at %0t: bus answer never came", $time);
      tally_and_finish();
    end
  endtask : overrun

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  // Ready and valid are registered, so they are looked at on the falling
  // edge and acted on at the following rising edge.
  task axi_write(input logic [11:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t, done;
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done)
    begin
      @(negedge sys_clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      if (b_t)
        resp = bresp;
      @(posedge sys_clk);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
      if (b_t)
        bready <= 1'b0;
      done = b_t;
      n++;
      overrun(n);
    end
  endtask : axi_write

  task axi_read(input logic [11:0] a);
    logic ar_t, r_t;
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    n = 0;
    while (!r_t)
    begin
      @(negedge sys_clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      if (r_t)
      begin
        rd = rdata;
        resp = rresp;
      end
      @(posedge sys_clk);
      if (ar_t)
        arvalid <= 1'b0;
      if (r_t)
        rready <= 1'b0;
      n++;
      overrun(n);
    end
  endtask : axi_read

  // Outputs follow one edge after the store, targets one edge later.
  task settle;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task check_out(input led_drive_pkg::drive_setting_type em,
                 input led_drive_pkg::drive_target_type tg,
                 input logic lp, input logic [3:0] s,
                 input logic [3:0] e, input logic [3:0] c,
                 input logic [4:0] f);
    check({19'h0, em}, {19'h0, s[0], e[2:0], c, f});
    check({31'h0, lp}, {31'h0, ~s[0]});
    check(tg.coarse_micro,
          `COARSE_BASE_MILLI + `COARSE_STEP_MILLI * c);
    check(tg.fine_milli,
          `FINE_BASE_MILLI + `FINE_STEP_MILLI * f);
    check(tg.scale_milli,
          `SCALE_BASE_MILLI + `SCALE_STEP_MILLI * s[0]);
  endtask : check_out

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    check_out(em1, tg1, lp1, 4'h1, 4'h0, 4'h0, 5'h0c);
    check_out(em2, tg2, lp2, 4'h1, 4'h0, 4'h0, 5'h0c);
    axi_read(`FIRST_DRIVE_ADDR);
    check(rd, 32'h0000_3000);
    axi_read(`SECOND_DRIVE_ADDR);
    check(rd, 32'h0000_3000);
    axi_read(`FINE_ADJUST_ADDR);
    check(rd, 32'h0000_030c);
    $display("test reset values done");

    // Low-power, fastest edge and top coarse code on the first sink.
    axi_write(`FIRST_DRIVE_ADDR, 32'h0000_107f);
    check({30'h0, resp}, 32'h0);
    settle();
    check_out(em1, tg1, lp1, 4'h0, 4'h7, 4'hf, 5'h0c);
    axi_read(`FIRST_DRIVE_ADDR);
    check(rd, 32'h0000_107f);
    check_out(em2, tg2, lp2, 4'h1, 4'h0, 4'h0, 5'h0c);
    $display("test first drive done");

    // Every coarse and edge code on the second sink, scale toggling.
    for (int k = 0; k < 16; k++)
    begin
      axi_write(`SECOND_DRIVE_ADDR, 32'h1000 | (k[0] << 13) |
                ((k & 7) << 4) | k);
      settle();
      check_out(em2, tg2, lp2, {3'h0, k[0]}, {1'b0, k[2:0]}, k[3:0],
                5'h0c);
    end
    check({19'h0, em1}, {19'h0, 1'b0, 3'h7, 4'hf, 5'h0c});
    $display("test second drive done");

    // Fine codes at their extremes, each reaching only its own sink.
    axi_write(`FINE_ADJUST_ADDR, 32'h0000_001f);
    settle();
    check_out(em1, tg1, lp1, 4'h0, 4'h7, 4'hf, 5'h1f);
    check(tg2.fine_milli, `FINE_BASE_MILLI);
    axi_write(`FINE_ADJUST_ADDR, 32'h0000_07c0);
    settle();
    check(tg1.fine_milli, `FINE_BASE_MILLI);
    check(tg2.fine_milli, `FINE_BASE_MILLI + `FINE_STEP_MILLI * 31);
    check({27'h0, em2.fine_code}, 32'h1f);
    axi_read(`FINE_ADJUST_ADDR);
    check(rd, 32'h0000_07c0);
    $display("test fine adjust done");

    // An unmapped place answers with an error and stores nothing.
    axi_write(12'h098, 32'h0000_0000);
    check({30'h0, resp}, 32'h2);
    axi_read(12'h098);
    check({30'h0, resp}, 32'h2);
    check(rd, 32'h0);
    axi_read(`FIRST_DRIVE_ADDR);
    check(rd, 32'h0000_107f);
    $display("test unmapped access done");

    // A low enable holds the targets while the new setting stands.
    axi_write(`FIRST_DRIVE_ADDR, 32'h0000_3025);
    clk_en <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check({19'h0, em1}, {19'h0, 1'b1, 3'h2, 4'h5, 5'h00});
    check({31'h0, lp1}, 32'h0);
    check(tg1.coarse_micro,
          `COARSE_BASE_MILLI + `COARSE_STEP_MILLI * 15);
    check(tg1.scale_milli, `SCALE_BASE_MILLI);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    settle();
    check_out(em1, tg1, lp1, 4'h1, 4'h2, 4'h5, 5'h00);
    $display("test clock enable freeze done");

    // A reset in mid-run brings back every reset value.
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    check_out(em1, tg1, lp1, 4'h1, 4'h0, 4'h0, 5'h0c);
    check_out(em2, tg2, lp2, 4'h1, 4'h0, 4'h0, 5'h0c);
    axi_read(`FINE_ADJUST_ADDR);
    check(rd, 32'h0000_030c);
    axi_read(`SECOND_DRIVE_ADDR);
    check(rd, 32'h0000_3000);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : led_drive_config_regs_tb
